/* File: src/lpp_encoder.sv */
// Land pre-pit block encoder with its input frame FIFO
`timescale 1ns/100ps

// ---------------------------------------------------------------
// Frame FIFO
// ---------------------------------------------------------------
module lpp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } lpp_fifo_s;

  lpp_fifo_s st_q;
  lpp_fifo_s st_d;
  logic      push;
  logic      pop;

  assign in_ready  = (st_q.count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (st_q.count != '0) ? 1'b1 : 1'b0;
  assign out_data  = st_q.mem[st_q.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr           = (st_q.wr == AW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = (st_q.rd == AW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
    end
    st_d.count = st_q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : lpp_fifo

// ---------------------------------------------------------------
// Encoder top
// ---------------------------------------------------------------
module lpp_encoder
  import lpp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RESET_IN,
  // Block content
  input  wire lpp_block_s BLOCK_IN,
  input  wire logic       BLOCK_VALID_IN,
  output logic            BLOCK_READY_OUT,
  // Position choice for the next block
  input  wire logic       NEIGHBOUR_PIT_IN,
  // Groove timing
  input  wire logic       SYNC_PAIR_IN,
  // Pit set output
  output lpp_set_s        SET_OUT,
  output logic            SET_STROBE_OUT,
  output logic            BLOCK_START_OUT,
  output logic            UNDERRUN_OUT
);

  // Frame word: relative address and user byte, plus odd-position and block-start flags
  localparam int FW = FRAME_BITS + 2;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_FILL = 3'b010,
    ST_WAIT = 3'b100
  } lpp_load_e;

  typedef struct packed {
    lpp_load_e                   load;
    lpp_block_s                  blk;
    logic                        odd;
    logic [3:0]                  frame;
    logic [2:0]                  sp_sync;
    logic                        pair_lvl;
    logic [FRAME_BITS-1:0]       shift;
    logic [3:0]                  set_idx;
    logic                        active;
    logic                        cur_odd;
    logic [3:0]                  sector;
    lpp_set_s                    set;
    logic                        strobe;
    logic                        bstart;
    logic                        underrun;
    logic                        ready;
  } lpp_top_s;

  lpp_top_s         st_q;
  lpp_top_s         st_d;
  logic             f_in_valid;
  logic             f_in_ready;
  logic [FW-1:0]    f_in_data;
  logic             f_out_valid;
  logic             f_out_ready;
  logic [FW-1:0]    f_out_data;
  logic             pair_edge;

  // Byte carried by each relative address
  function automatic logic [7:0] frame_byte(input lpp_block_s b, input logic [3:0] ra);
    logic [7:0] v;
    v = 8'h00;
    unique case (ra)
      4'h0: v = b.block_address[23:16];
      4'h1: v = b.block_address[15:8];
      4'h2: v = b.block_address[7:0];
      4'h3: v = b.parity_a[23:16];
      4'h4: v = b.parity_a[15:8];
      4'h5: v = b.parity_a[7:0];
      4'h6: v = b.block_field_identifier;
      4'h7: v = b.disc_info[47:40];
      4'h8: v = b.disc_info[39:32];
      4'h9: v = b.disc_info[31:24];
      4'hA: v = b.disc_info[23:16];
      4'hB: v = b.disc_info[15:8];
      4'hC: v = b.disc_info[7:0];
      4'hD: v = b.parity_b[23:16];
      4'hE: v = b.parity_b[15:8];
      4'hF: v = b.parity_b[7:0];
    endcase
    return v;
  endfunction : frame_byte

  lpp_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK_IN),
    .rst       (RESET_IN),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // Groove pair pulse arrives from pin: three-stage sync, second and third agree
  assign pair_edge   = st_q.sp_sync[1] & st_q.sp_sync[2] & ~st_q.pair_lvl;
  assign f_in_valid  = (st_q.load == ST_FILL) ? 1'b1 : 1'b0;
  assign f_in_data   = {(st_q.frame == 4'h0), st_q.odd, st_q.frame, frame_byte(st_q.blk, st_q.frame)};
  // Next frame taken when a new sector begins
  assign f_out_ready = pair_edge & (~st_q.active | (st_q.set_idx == 4'(SETS_PER_SECTOR - 1)));

  always_comb begin
    st_d          = st_q;
    st_d.sp_sync  = {st_q.sp_sync[1:0], SYNC_PAIR_IN};
    // Level only moves once the last two stages agree
    if (st_q.sp_sync[1] == st_q.sp_sync[2]) begin
      st_d.pair_lvl = st_q.sp_sync[2];
    end
    st_d.strobe   = 1'b0;
    st_d.bstart   = 1'b0;
    st_d.ready    = 1'b0;

    // Block loader
    unique case (st_q.load)
      ST_LOAD: begin
        st_d.ready = 1'b1;
        if (st_q.ready && BLOCK_VALID_IN) begin
          st_d.blk   = BLOCK_IN;
          st_d.odd   = NEIGHBOUR_PIT_IN;
          st_d.frame = 4'h0;
          st_d.ready = 1'b0;
          st_d.load  = ST_FILL;
        end
      end
      ST_FILL: begin
        if (f_in_ready) begin
          st_d.frame = st_q.frame + 4'h1;
          if (st_q.frame == 4'(SECTORS_PER_BLK - 1)) begin
            st_d.load = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        st_d.load = ST_LOAD;
      end
    endcase

    // Set emission, one per groove sync frame pair
    if (pair_edge) begin
      st_d.strobe = 1'b1;
      if (f_out_ready) begin
        if (f_out_valid) begin
          st_d.active   = 1'b1;
          st_d.shift    = f_out_data[FRAME_BITS-1:0];
          st_d.cur_odd  = f_out_data[FRAME_BITS];
          st_d.sector   = f_out_data[FRAME_BITS-1:DATA_BITS];
          st_d.bstart   = f_out_data[FRAME_BITS+1];
          st_d.set_idx  = 4'h0;
          st_d.set.bits = f_out_data[FRAME_BITS] ? SYNC_ODD : SYNC_EVEN;
          st_d.set.sync_set = 1'b1;
          st_d.set.odd_pos  = f_out_data[FRAME_BITS];
          st_d.set.sector   = f_out_data[FRAME_BITS-1:DATA_BITS];
        end else begin
          st_d.active   = 1'b0;
          st_d.underrun = st_q.active | st_q.underrun;
          st_d.set      = '0;
          st_d.set.bits = SET_IDLE;
          st_d.strobe   = 1'b0;
        end
      end else begin
        st_d.set_idx  = st_q.set_idx + 4'h1;
        st_d.set.bits = st_q.shift[FRAME_BITS-1] ? DATA_ONE : DATA_ZERO;
        st_d.shift    = {st_q.shift[FRAME_BITS-2:0], 1'b0};
        st_d.set.sync_set = 1'b0;
        st_d.set.odd_pos  = st_q.cur_odd;
        st_d.set.sector   = st_q.sector;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      st_q      <= '0;
      st_q.load <= ST_LOAD;
    end else begin
      st_q <= st_d;
    end
  end

  assign SET_OUT         = st_q.set;
  assign SET_STROBE_OUT  = st_q.strobe;
  assign BLOCK_START_OUT = st_q.bstart;
  assign UNDERRUN_OUT    = st_q.underrun;
  assign BLOCK_READY_OUT = st_q.ready;

endmodule : lpp_encoder

/* File: src/lpp_pkg.sv */
// Package of constants and types for the land pre-pit block encoder
// ---------------------------------------------------------------
// How it works
// - One 3-bit pit set, b2 first, is emitted every two groove sync frames.
// - First set of each sector is the sync code; its lead bit marks sync frame.
// - Each set's leading bit aligns with the groove sync code position.
// - Sync code in even position is 111.
// - Sync code in odd position is 110.
// - Even position by default; odd when neighbouring land already holds a pit.
// - A data frame is a 4-bit relative address then 8 user data bits.
// - Data one becomes 101, zero becomes 100; sector is 3+12+24 bits.
// - The sector is the smallest unit; a physical block holds sixteen sectors.
// - A data block holds sixteen frames with relative addresses 0 to 15.
// - Frames 0 to 5 carry three address bytes then three parity A bytes.
// - Frames 6 to 15 carry field identifier, six info bytes, three parity B.
// - One block spans sixteen sectors, aligned with one groove ECC block.
// - The block address is the absolute track address, rising outward.
// ---------------------------------------------------------------
package lpp_pkg;

  localparam int          SET_BITS         = 3;
  localparam int          ADDR_BITS        = 4;
  localparam int          DATA_BITS        = 8;
  localparam int          FRAME_BITS       = ADDR_BITS + DATA_BITS;
  localparam int          SETS_PER_SECTOR  = FRAME_BITS + 1;
  localparam int          SECTORS_PER_BLK  = 16;
  localparam int          BYTES_PER_BLK    = 16;
  localparam int          PART_A_FRAMES    = 6;
  localparam int          PART_B_FRAMES    = 10;
  localparam logic [3:0]  PART_B_FIRST     = 4'h6;
  localparam logic [2:0]  SYNC_EVEN        = 3'h7;
  localparam logic [2:0]  SYNC_ODD         = 3'h6;
  localparam logic [2:0]  DATA_ONE         = 3'h5;
  localparam logic [2:0]  DATA_ZERO        = 3'h4;
  localparam logic [2:0]  SET_IDLE         = 3'h0;

  // Block content as written by the mastering side
  typedef struct packed {
    logic [23:0] block_address;
    logic [23:0] parity_a;
    logic [7:0]  block_field_identifier;
    logic [47:0] disc_info;
    logic [23:0] parity_b;
  } lpp_block_s;

  // Pit set going out, one per sync frame pair
  typedef struct packed {
    logic [2:0] bits;
    logic       sync_set;
    logic       odd_pos;
    logic [3:0] sector;
  } lpp_set_s;

endpackage : lpp_pkg

/* File: tb/lpp_encoder_props.sv */
// Concurrent checks on the pre-pit encoder ports
`timescale 1ns/100ps
module lpp_encoder_props
  import lpp_pkg::*;
(
  input wire logic       CLK_IN,
  input wire logic       RESET_IN,
  input wire lpp_block_s BLOCK_IN,
  input wire logic       BLOCK_VALID_IN,
  input wire logic       BLOCK_READY_OUT,
  input wire logic       NEIGHBOUR_PIT_IN,
  input wire logic       SYNC_PAIR_IN,
  input wire lpp_set_s   SET_OUT,
  input wire logic       SET_STROBE_OUT,
  input wire logic       BLOCK_START_OUT,
  input wire logic       UNDERRUN_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  lead_bit_a: assert property (SET_STROBE_OUT |-> SET_OUT.bits[2])
    else $error("pit set without lead bit");
  sync_even_a: assert property (SET_STROBE_OUT && SET_OUT.sync_set && !SET_OUT.odd_pos |-> SET_OUT.bits == 3'h7)
    else $error("even sync code wrong");
  sync_odd_a: assert property (SET_STROBE_OUT && SET_OUT.sync_set && SET_OUT.odd_pos |-> SET_OUT.bits == 3'h6)
    else $error("odd sync code wrong");
  data_code_a: assert property (SET_STROBE_OUT && !SET_OUT.sync_set |-> SET_OUT.bits inside {3'h5, 3'h4})
    else $error("data set code wrong");
  block_start_a: assert property (BLOCK_START_OUT |-> SET_STROBE_OUT && SET_OUT.sync_set && SET_OUT.sector == 4'h0)
    else $error("block start not on sector zero sync");
  sector_hold_a: assert property (SET_STROBE_OUT && !SET_OUT.sync_set |-> SET_OUT.sector == $past(SET_OUT.sector))
    else $error("sector changed inside sector");
  pos_hold_a: assert property (SET_STROBE_OUT && !BLOCK_START_OUT |-> SET_OUT.odd_pos == $past(SET_OUT.odd_pos))
    else $error("position changed inside block");
  ready_drop_a: assert property (BLOCK_READY_OUT && BLOCK_VALID_IN |=> !BLOCK_READY_OUT [*2])
    else $error("ready stayed high after take");
endmodule : lpp_encoder_props

bind lpp_encoder lpp_encoder_props lpp_encoder_props_inst (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .BLOCK_IN(BLOCK_IN),
  .BLOCK_VALID_IN(BLOCK_VALID_IN), .BLOCK_READY_OUT(BLOCK_READY_OUT), .NEIGHBOUR_PIT_IN(NEIGHBOUR_PIT_IN),
  .SYNC_PAIR_IN(SYNC_PAIR_IN), .SET_OUT(SET_OUT), .SET_STROBE_OUT(SET_STROBE_OUT),
  .BLOCK_START_OUT(BLOCK_START_OUT), .UNDERRUN_OUT(UNDERRUN_OUT));

/* File: tb/lpp_drive_model.sv */
// Drive-side groove timing and pre-pit decoder model
`timescale 1ns/100ps
module lpp_drive_model
  import lpp_pkg::*;
#(
  parameter int PERIOD = 8
) (
  input  wire logic     clk_in,
  input  wire logic     rst_in,
  input  wire lpp_set_s set_in,
  input  wire logic     strobe_in,
  output logic          sync_pair_out,
  output logic [12:0]   frame_out,
  output logic          frame_valid_out,
  output logic          error_out
);
  int          tick = 0;
  int          cnt  = 0;
  logic        odd  = 1'b0;
  logic [11:0] shf  = '0;
  assign sync_pair_out = (tick < 2);
  always @(posedge clk_in) begin
    tick <= (tick == PERIOD - 1) ? 0 : tick + 1;
    frame_valid_out <= 1'b0;
    if (rst_in) begin
      cnt <= 0;
      error_out <= 1'b0;
    end else if (strobe_in) begin
      if (!set_in.bits[2]) error_out <= 1'b1;
      if (set_in.bits[1]) begin
        if (cnt != 0 && cnt != 13) error_out <= 1'b1;
        cnt <= 1;
        odd <= !set_in.bits[0];
      end else if (cnt == 0 || cnt == 13) begin
        error_out <= 1'b1;
      end else begin
        shf <= {shf[10:0], set_in.bits[0]};
        cnt <= cnt + 1;
        if (cnt == 12) begin
          frame_out <= {odd, shf[10:0], set_in.bits[0]};
          frame_valid_out <= 1'b1;
        end
      end
    end
  end
endmodule : lpp_drive_model

/* File: tb/tb_top.sv */
// Self-checking testbench for the pre-pit block encoder
`timescale 1ns/100ps
module tb_top;
  import lpp_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  lpp_block_s  blk = '0;
  logic        blk_valid = 1'b0;
  logic        nb_pit = 1'b0;
  logic        ready, strobe, bstart, underrun, sync_pair, fv, derr;
  lpp_set_s    set_q;
  logic [12:0] frame;
  logic [12:0] frames[$];
  int          n_start = 0;
  int          err_count = 0;
  int          n_tests = 0;
  always #5 clk = ~clk;
  lpp_encoder #(.FIFO_DEPTH(16)) lpp_encoder_inst (.CLK_IN(clk), .RESET_IN(rst), .BLOCK_IN(blk),
    .BLOCK_VALID_IN(blk_valid), .BLOCK_READY_OUT(ready), .NEIGHBOUR_PIT_IN(nb_pit), .SYNC_PAIR_IN(sync_pair),
    .SET_OUT(set_q), .SET_STROBE_OUT(strobe), .BLOCK_START_OUT(bstart), .UNDERRUN_OUT(underrun));
  lpp_drive_model #(.PERIOD(8)) lpp_drive_model_inst (.clk_in(clk), .rst_in(rst), .set_in(set_q),
    .strobe_in(strobe), .sync_pair_out(sync_pair), .frame_out(frame), .frame_valid_out(fv), .error_out(derr));
  always @(posedge clk) begin
    if (fv) frames.push_back(frame);
    if (bstart === 1'b1) n_start++;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic send_block(input lpp_block_s b, input logic pos);
    int k;
    @(posedge clk);
    #1;
    blk = b;
    nb_pit = pos;
    blk_valid = 1'b1;
    k = 0;
    while (ready !== 1'b1 && k < 5000) begin @(posedge clk); #1; k++; end
    @(posedge clk);
    #1;
    blk_valid = 1'b0;
    check("take_timeout", {31'h0, (k >= 5000)}, 32'h0);
    check("ready_after_take", {31'h0, ready}, 32'h0);
  endtask : send_block
  task automatic expect_block(input lpp_block_s b, input logic pos);
    int k;
    logic [12:0] f;
    k = 0;
    while (frames.size() < 16 && k < 5000) begin @(posedge clk); k++; end
    for (int i = 0; i < 16; i++) begin
      f = (frames.size() > 0) ? frames.pop_front() : 13'h1FFF;
      check("frame", {19'h0, f}, {19'h0, pos, i[3:0], b[127 - 8 * i -: 8]});
    end
    check("decode_error", {31'h0, derr}, 32'h0);
  endtask : expect_block
  task automatic test_even;
    lpp_block_s b;
    b = {24'h003000, 24'hA55AC3, 8'h81, 48'h0123456789AB, 24'hFF007E};
    send_block(b, 1'b0);
    expect_block(b, 1'b0);
    check("block_starts", n_start, 32'h1);
    $display("test_even done");
  endtask : test_even
  task automatic test_back_to_back;
    lpp_block_s b2;
    lpp_block_s b3;
    b2 = {24'h00223C, 24'h0F0F0F, 8'hFE, 48'hFFFFFFFFFFFF, 24'h000001};
    b3 = {24'h00223D, 24'h800000, 8'h00, 48'h000000000000, 24'h7FFFFF};
    // Mid-run reset clears the active state, so the previous block leaves no sticky underrun
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    send_block(b2, 1'b1);
    send_block(b3, 1'b0);
    expect_block(b2, 1'b1);
    check("no_underrun", {31'h0, underrun}, 32'h0);
    expect_block(b3, 1'b0);
    check("block_starts", n_start, 32'h3);
    $display("test_back_to_back done");
  endtask : test_back_to_back
  task automatic test_underrun;
    repeat (13 * 8 * 2) @(posedge clk);
    check("underrun", {31'h0, underrun}, 32'h1);
    $display("test_underrun done");
  endtask : test_underrun
  task automatic print_verdict;
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial begin
    #150000;
    err_count++;
    $display("Watchdog expired");
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    test_even;
    test_back_to_back;
    test_underrun;
    print_verdict;
  end
endmodule : tb_top
